// >>> src/rtcrd_pkg.sv
// Constants, types and states for the clock chip's two-wire read-mode slave port
package rtcrd_pkg;

  // Bus address and direction
  localparam logic [6:0] RTCRD_SLAVE_ADDR = 7'h68;
  localparam logic RTCRD_DIR_READ = 1'b1;

  // Widths and counts
  localparam int RTCRD_PTR_W = 6;
  localparam int RTCRD_DATA_W = 8;
  localparam logic [5:0] RTCRD_PTR_RST = 6'h00;
  localparam logic [5:0] RTCRD_PTR_STEP = 6'h01;
  localparam logic [3:0] RTCRD_ADDR_BITS = 4'h8;
  localparam logic [3:0] RTCRD_LAST_BIT = 4'h7;
  localparam logic [3:0] RTCRD_BIT_STEP = 4'h1;

  // Data hold after SCL falls, in ns, and its cycle count at 200 MHz
  localparam int RTCRD_CLK_PS = 5000;
  localparam int RTCRD_HOLD_NS = 300;
  localparam int RTCRD_HOLD_CYC_I = (RTCRD_HOLD_NS * 1000 + RTCRD_CLK_PS - 1) / RTCRD_CLK_PS;
  localparam logic [6:0] RTCRD_HOLD_CYC = 7'(RTCRD_HOLD_CYC_I);
  localparam logic [6:0] RTCRD_HOLD_ONE = 7'h01;
  localparam logic [6:0] RTCRD_HOLD_ZERO = 7'h00;

  // Transfer states, Gray coded along the read path
  typedef enum logic [2:0] {
    RTCRD_ST_IDLE = 3'b000,
    RTCRD_ST_ADDR = 3'b001,
    RTCRD_ST_AACK = 3'b011,
    RTCRD_ST_TX   = 3'b010,
    RTCRD_ST_MACK = 3'b110
  } rtcrd_st_t;

  // Raw or synchronised line levels
  typedef struct packed {
    logic scl;
    logic sda;
  } rtcrd_line_t;

  // Line events seen in the core clock domain
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } rtcrd_evt_t;

  // Pointer load from the write path
  typedef struct packed {
    logic en;
    logic [RTCRD_PTR_W-1:0] val;
  } rtcrd_ptr_ld_t;

  // Synchroniser state: two stages plus an edge stage
  typedef struct packed {
    rtcrd_line_t s1;
    rtcrd_line_t s2;
    rtcrd_line_t s3;
  } rtcrd_sync_st_t;

  // Core state
  typedef struct packed {
    rtcrd_st_t st;
    logic [3:0] bits;
    logic [RTCRD_DATA_W-1:0] shreg;
    logic [RTCRD_PTR_W-1:0] ptr;
    logic [6:0] hold;
    logic pin_low;
  } rtcrd_core_t;

endpackage : rtcrd_pkg

// >>> src/rtcrd_linesync.sv
// Two-stage synchroniser, START/STOP finder for SCL and SDA, and edge finder for SCL
`timescale 1ns/1ps
module rtcrd_linesync
(
  input wire logic core_clk,
  input wire logic reset,
  input rtcrd_pkg::rtcrd_line_t line_raw,
  output rtcrd_pkg::rtcrd_evt_t ev
);
  import rtcrd_pkg::*;

  rtcrd_sync_st_t r_ff;
  rtcrd_sync_st_t nxt_r;

  // Shift both lines through the stages
  always_comb
  begin
    nxt_r = r_ff;
    nxt_r.s1 = line_raw;
    nxt_r.s2 = r_ff.s1;
    nxt_r.s3 = r_ff.s2;
  end

  // Idle bus reads high
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      r_ff <= '{s1: '{scl: 1'b1, sda: 1'b1}, s2: '{scl: 1'b1, sda: 1'b1}, s3: '{scl: 1'b1, sda: 1'b1}};
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  // Events from stage two against stage three only
  always_comb
  begin
    ev.scl = r_ff.s2.scl;
    ev.sda = r_ff.s2.sda;
    ev.scl_rise = r_ff.s2.scl & ~r_ff.s3.scl;
    ev.scl_fall = ~r_ff.s2.scl & r_ff.s3.scl;
    ev.start = r_ff.s2.scl & r_ff.s3.scl & ~r_ff.s2.sda & r_ff.s3.sda;
    ev.stop = r_ff.s2.scl & r_ff.s3.scl & r_ff.s2.sda & ~r_ff.s3.sda;
  end

endmodule : rtcrd_linesync

// >>> src/rtcrd_read_slave.sv
// Read-mode slave transmitter of the clock chip's two-wire port
`timescale 1ns/1ps
module rtcrd_read_slave
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input rtcrd_pkg::rtcrd_ptr_ld_t ptr_ld,
  output logic [rtcrd_pkg::RTCRD_PTR_W-1:0] ptr_o,
  output logic [rtcrd_pkg::RTCRD_PTR_W-1:0] rd_addr,
  input wire logic [rtcrd_pkg::RTCRD_DATA_W-1:0] rd_data,
  output logic rd_active
);
  import rtcrd_pkg::*;

  rtcrd_line_t line_raw;
  rtcrd_evt_t ev;
  rtcrd_core_t r_ff;
  rtcrd_core_t nxt_r;
  logic drive_tgt;
  logic addr_hit;

  assign line_raw = '{scl: scl_i, sda: sda_i};

  // Pin synchroniser and condition finder
  rtcrd_linesync u_sync
  (
    .core_clk(core_clk),
    .reset(reset),
    .line_raw(line_raw),
    .ev(ev)
  );

  // Level the pin should take once the hold time is over
  assign drive_tgt = (r_ff.st == RTCRD_ST_AACK) || (r_ff.st == RTCRD_ST_TX && !r_ff.shreg[RTCRD_DATA_W-1]);
  assign addr_hit = (r_ff.shreg[7:1] == RTCRD_SLAVE_ADDR) && (r_ff.shreg[0] == RTCRD_DIR_READ);

  // Transfer sequencing
  always_comb
  begin
    nxt_r = r_ff;
    if (r_ff.hold != RTCRD_HOLD_ZERO)
    begin
      nxt_r.hold = r_ff.hold - RTCRD_HOLD_ONE;
    end
    if (r_ff.hold == RTCRD_HOLD_ONE)
    begin
      nxt_r.pin_low = drive_tgt;
    end
    if (ptr_ld.en)
    begin
      nxt_r.ptr = ptr_ld.val;
    end
    if (ev.start)
    begin
      nxt_r.st = RTCRD_ST_ADDR;
      nxt_r.bits = 4'h0;
      nxt_r.hold = RTCRD_HOLD_ZERO;
      nxt_r.pin_low = 1'b0;
    end
    else if (ev.stop)
    begin
      nxt_r.st = RTCRD_ST_IDLE;
      nxt_r.hold = RTCRD_HOLD_ZERO;
      nxt_r.pin_low = 1'b0;
    end
    else
    begin
      case (r_ff.st)
        RTCRD_ST_IDLE:
        begin
          nxt_r.st = RTCRD_ST_IDLE;
        end
        RTCRD_ST_ADDR:
        begin
          if (ev.scl_rise && r_ff.bits != RTCRD_ADDR_BITS)
          begin
            nxt_r.shreg = {r_ff.shreg[RTCRD_DATA_W-2:0], ev.sda};
            nxt_r.bits = r_ff.bits + RTCRD_BIT_STEP;
          end
          else if (ev.scl_fall && r_ff.bits == RTCRD_ADDR_BITS)
          begin
            if (addr_hit)
            begin
              nxt_r.st = RTCRD_ST_AACK;
              nxt_r.hold = RTCRD_HOLD_CYC;
            end
            else
            begin
              nxt_r.st = RTCRD_ST_IDLE;
            end
          end
        end
        RTCRD_ST_AACK:
        begin
          if (ev.scl_fall)
          begin
            nxt_r.st = RTCRD_ST_TX;
            nxt_r.shreg = rd_data;
            nxt_r.bits = 4'h0;
            nxt_r.hold = RTCRD_HOLD_CYC;
          end
        end
        RTCRD_ST_TX:
        begin
          if (ev.scl_fall)
          begin
            nxt_r.hold = RTCRD_HOLD_CYC;
            if (r_ff.bits == RTCRD_LAST_BIT)
            begin
              nxt_r.st = RTCRD_ST_MACK;
              nxt_r.ptr = r_ff.ptr + RTCRD_PTR_STEP;
            end
            else
            begin
              nxt_r.shreg = {r_ff.shreg[RTCRD_DATA_W-2:0], 1'b0};
              nxt_r.bits = r_ff.bits + RTCRD_BIT_STEP;
            end
          end
        end
        RTCRD_ST_MACK:
        begin
          if (ev.scl_rise && ev.sda)
          begin
            nxt_r.st = RTCRD_ST_IDLE;
            nxt_r.hold = RTCRD_HOLD_ZERO;
            nxt_r.pin_low = 1'b0;
          end
          else if (ev.scl_fall)
          begin
            nxt_r.st = RTCRD_ST_TX;
            nxt_r.shreg = rd_data;
            nxt_r.bits = 4'h0;
            nxt_r.hold = RTCRD_HOLD_CYC;
          end
        end
        default:
        begin
          nxt_r.st = RTCRD_ST_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      r_ff <= '{st: RTCRD_ST_IDLE, bits: 4'h0, shreg: 8'h00, ptr: RTCRD_PTR_RST, hold: 7'h00, pin_low: 1'b0};
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  // Open-drain pin: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe = r_ff.pin_low;
  assign ptr_o = r_ff.ptr;
  assign rd_addr = r_ff.ptr;
  assign rd_active = (r_ff.st != RTCRD_ST_IDLE);

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  logic quiet;
  logic nack_now;
  assign quiet = !ev.start && !ev.stop;
  // Master not-acknowledge seen this cycle
  assign nack_now = (r_ff.st == RTCRD_ST_MACK) && ev.scl_rise && ev.sda && quiet;

  sequence s_addr_done;
    r_ff.st == RTCRD_ST_ADDR && r_ff.bits == RTCRD_ADDR_BITS && ev.scl_fall && quiet;
  endsequence

  sequence s_master_nack;
    r_ff.st == RTCRD_ST_MACK && ev.scl_rise && ev.sda && quiet;
  endsequence

  property p_start;
    ev.start |=> r_ff.st == RTCRD_ST_ADDR && r_ff.bits == 4'h0 && !sda_oe;
  endproperty
  a_start: assert property (p_start) else $error("START did not begin address phase");

  property p_addr_miss;
    s_addr_done and (r_ff.shreg[7:1] != RTCRD_SLAVE_ADDR) |=> r_ff.st == RTCRD_ST_IDLE;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("Foreign address not ignored");

  property p_addr_read;
    s_addr_done and addr_hit |=> r_ff.st == RTCRD_ST_AACK ##60 sda_oe;
  endproperty
  a_addr_read: assert property (p_addr_read) else $error("Read address not acknowledged");

  property p_addr_write;
    s_addr_done and (r_ff.shreg[0] != RTCRD_DIR_READ) |=> r_ff.st == RTCRD_ST_IDLE;
  endproperty
  a_addr_write: assert property (p_addr_write) else $error("Write direction entered read mode");

  property p_ack_hold;
    r_ff.st == RTCRD_ST_AACK && r_ff.hold == RTCRD_HOLD_ZERO |-> sda_oe;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("Acknowledge not driven low");

  property p_tx_bit;
    r_ff.st == RTCRD_ST_TX && r_ff.hold == RTCRD_HOLD_ZERO |-> sda_oe == !r_ff.shreg[RTCRD_DATA_W-1];
  endproperty
  a_tx_bit: assert property (p_tx_bit) else $error("Data pin does not show current bit");

  property p_load;
    r_ff.st == RTCRD_ST_TX && $past(r_ff.st) != RTCRD_ST_TX |-> r_ff.shreg == $past(rd_data);
  endproperty
  a_load: assert property (p_load) else $error("Byte not loaded from pointed register");

  property p_ptr_keep;
    r_ff.st == RTCRD_ST_ADDR && !ptr_ld.en |=> r_ff.ptr == $past(r_ff.ptr);
  endproperty
  a_ptr_keep: assert property (p_ptr_keep) else $error("Pointer changed during address phase");

  property p_ack_more;
    r_ff.st == RTCRD_ST_MACK && ev.scl_fall && quiet |=> r_ff.st == RTCRD_ST_TX;
  endproperty
  a_ack_more: assert property (p_ack_more) else $error("Next byte not sent after acknowledge");

  property p_nack;
    s_master_nack |=> (r_ff.st == RTCRD_ST_IDLE && !sda_oe) [*3];
  endproperty
  a_nack: assert property (p_nack) else $error("Data line not released after not-acknowledge");

  property p_ptr_inc;
    r_ff.st == RTCRD_ST_MACK && $past(r_ff.st) == RTCRD_ST_TX && !$past(ptr_ld.en)
      |-> r_ff.ptr == $past(r_ff.ptr) + RTCRD_PTR_STEP;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("Pointer not advanced after byte");

  property p_scl_low;
    $changed(sda_oe) && !$past(ev.start) && !$past(ev.stop) && !$past(nack_now) |-> !ev.scl;
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("Data line changed while clock high");

endmodule : rtcrd_read_slave

// >>> test/rtcrd_master.sv
// Two-wire bus master model that clocks reads out of the slave
`timescale 1ns/1ps
module rtcrd_master
(
  input wire logic core_clk,
  input wire logic sda,
  output logic scl,
  output logic pull_low
);
  localparam int LOW_CYC = 100;
  localparam int HIGH_CYC = 60;
  logic busy;
  logic res_kind;
  logic [7:0] res_val;
  event got;

  // Idle bus: clock stands high, data released
  initial
  begin
    scl = 1'b1;
    pull_low = 1'b0;
    busy = 1'b0;
  end

  // One clock pulse; data changes only while SCL is low, sampled mid-high
  task automatic pulse(input logic b, output logic r);
    scl = 1'b0;
    repeat (4) @(negedge core_clk);
    pull_low = !b;
    repeat (LOW_CYC - 4) @(negedge core_clk);
    scl = 1'b1;
    repeat (HIGH_CYC / 2) @(negedge core_clk);
    r = sda;
    repeat (HIGH_CYC / 2) @(negedge core_clk);
  endtask : pulse

  // START, or repeated START when a transfer is still open
  task automatic start_cond();
    logic r;
    if (busy)
      pulse(1'b1, r);
    pull_low = 1'b1;
    repeat (HIGH_CYC) @(negedge core_clk);
    busy = 1'b1;
  endtask : start_cond

  // STOP: data rises while the clock is high
  task automatic stop_cond();
    scl = 1'b0;
    repeat (4) @(negedge core_clk);
    pull_low = 1'b1;
    repeat (LOW_CYC) @(negedge core_clk);
    scl = 1'b1;
    repeat (HIGH_CYC) @(negedge core_clk);
    pull_low = 1'b0;
    repeat (HIGH_CYC) @(negedge core_clk);
    busy = 1'b0;
  endtask : stop_cond

  // Hand one result to the bench
  task automatic emit(input logic k, input logic [7:0] v);
    res_kind = k;
    res_val = v;
    -> got;
  endtask : emit

  // Address byte, then n bytes acknowledged except the last
  task automatic xfer(input logic [7:0] abyte, input int n, input logic rs);
    logic r;
    logic a;
    logic [7:0] d;
    start_cond();
    for (int i = 7; i >= 0; i--)
      pulse(abyte[i], r);
    pulse(1'b1, a);
    emit(1'b0, {7'h00, a});
    if (!a && abyte[0])
    begin
      for (int k = 0; k < n; k++)
      begin
        for (int i = 0; i < 8; i++)
        begin
          pulse(1'b1, r);
          d = {d[6:0], r};
        end
        emit(1'b1, d);
        pulse(k == n - 1, r);
        if (k == n - 1)
          emit(1'b0, {7'h00, r});
      end
    end
    if (!rs)
      stop_cond();
  endtask : xfer
endmodule : rtcrd_master

// >>> test/tb_top.sv
// Self-checking bench for the read-mode slave port
`timescale 1ns/1ps
module tb_top;
  import rtcrd_pkg::*;
  typedef struct packed {
    logic kind;
    logic [7:0] val;
  } rtcrd_exp_t;
  logic core_clk;
  logic reset;
  logic scl;
  logic pull_low;
  logic sda_line;
  logic sda_o;
  logic sda_oe;
  rtcrd_ptr_ld_t ptr_ld;
  logic [5:0] ptr_o;
  logic [5:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_active;
  logic [7:0] mem [64];
  logic [31:0] seed;
  logic [5:0] mptr;
  rtcrd_exp_t expq [$];
  rtcrd_exp_t note;
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;

  // Pulled-up data wire and register file read port
  assign sda_line = ~(pull_low | (sda_oe & ~sda_o));
  assign rd_data = mem[rd_addr];

  rtcrd_read_slave uut
  (
    .core_clk(core_clk),
    .reset(reset),
    .scl_i(scl),
    .sda_i(sda_line),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .ptr_ld(ptr_ld),
    .ptr_o(ptr_o),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_active(rd_active)
  );

  rtcrd_master m
  (
    .core_clk(core_clk),
    .sda(sda_line),
    .scl(scl),
    .pull_low(pull_low)
  );

  // Clock
  always #2.5 core_clk = ~core_clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic finish_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic cmp_bit(input string what, input logic e, input logic g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %0b seen %0b", what, e, g);
    end
  endtask : cmp_bit

  task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %2h seen %2h", what, e, g);
    end
  endtask : cmp_byte

  task automatic cmp_ptr(input string what, input logic [5:0] e, input logic [5:0] g);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %2h seen %2h", what, e, g);
    end
  endtask : cmp_ptr

  // Pointer load as the write path would do it
  task automatic load_ptr(input logic [5:0] v);
    ptr_ld.en = 1'b1;
    ptr_ld.val = v;
    @(negedge core_clk);
    ptr_ld.en = 1'b0;
    mptr = v;
    @(negedge core_clk);
    cmp_ptr("pointer load", v, ptr_o);
  endtask : load_ptr

  // Note expected results, run the transfer, check the end state when it closes with a STOP
  task automatic rd(input logic [7:0] abyte, input int n, input logic rs);
    logic acked;
    acked = (abyte == {RTCRD_SLAVE_ADDR, RTCRD_DIR_READ});
    expq.push_back({1'b0, 7'h00, !acked});
    if (acked)
    begin
      for (int k = 0; k < n; k++)
      begin
        expq.push_back({1'b1, mem[mptr]});
        mptr = mptr + RTCRD_PTR_STEP;
      end
      expq.push_back({1'b0, 8'h01});
    end
    m.xfer(abyte, n, rs);
    if (!rs)
    begin
      cmp_ptr("pointer", mptr, ptr_o);
      cmp_bit("active", 1'b0, rd_active);
    end
  endtask : rd

  // Results seen by the master against the oldest note
  initial
  begin
    forever
    begin
      @(m.got);
      if (expq.size() == 0)
      begin
        failures++;
        $display("mismatch queue expected note seen none");
      end
      else
      begin
        note = expq.pop_front();
        cmp_bit("kind", note.kind, m.res_kind);
        cmp_bit("active", note.kind | !note.val[0], rd_active);
        if (note.kind)
          cmp_byte("data", note.val, m.res_val);
        else
          cmp_bit("ack", note.val[0], m.res_val[0]);
      end
    end
  end

  // Hang guard
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      failures++;
      finish_test();
    end
  end

  // Main sequence
  initial
  begin
    core_clk = 1'b0;
    reset = 1'b1;
    ptr_ld = '0;
    mptr = RTCRD_PTR_RST;
    seed = 32'h00007E6E;
    for (int i = 0; i < 64; i++)
    begin
      seed = xs(seed);
      mem[i] = seed[7:0];
    end
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    repeat (5) @(negedge core_clk);
    cmp_ptr("pointer after reset", RTCRD_PTR_RST, ptr_o);
    seed = xs(seed);
    load_ptr(seed[5:0]);
    rd(8'hD1, 3, 1'b0);
    rd(8'hD1, 2, 1'b0);
    load_ptr(6'h3E);
    rd(8'hD1, 3, 1'b0);
    rd(8'hD3, 1, 1'b0);
    rd(8'hD0, 1, 1'b0);
    rd(8'hD1, 1, 1'b1);
    rd(8'hD1, 2, 1'b0);
    if (expq.size() != 0)
    begin
      failures++;
      $display("mismatch queue expected empty seen %0d", expq.size());
    end
    finish_test();
  end
endmodule : tb_top
